// ==== hw/gpp_port.sv ====
// eight-pin general purpose I/O port with APB register access
// assumes APB master on i_sys_clk; pins are asynchronous; pads resolve
// output, active-low enable and pull requests into the physical wire
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "gpp_defs.svh"
module gpp_port (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // pins
  input wire logic [7:0] i_pin,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe_n,
  output logic [7:0] o_pull_up,
  output logic [7:0] o_pull_dn,
  // real-time clock to route out
  input wire logic i_rtc_clk,
  // interrupts, events, wake
  output logic [1:0] o_irq,
  output logic [7:0] o_event,
  output logic o_wake
);

  localparam gpp_pkg::gpp_state_t ST_RST = '{
    dir: `GPP_DIR_RST,
    out: `GPP_OUT_RST,
    pad_oe_n: `GPP_OE_N_RST,
    default: '0
  };

  gpp_pkg::gpp_state_t st;
  gpp_pkg::gpp_state_t next_st;

  logic [16:0] sync_in;
  logic [16:0] sync_out;
  logic [7:0] pin_s;
  logic rtc_s;
  logic [7:0] ahit;
  logic [7:0] ahit_s;
  logic [7:0] low_async;

  // async edge catchers, full support on pin 2 only
  genvar gi;
  generate
    for (gi = 0; gi < `GPP_NPINS; gi++) begin : g_pin
      gpp_edge_latch #(
        .FULL(gi == `GPP_FULL_ASYNC_PIN)
      ) u_latch (
        .i_pin(i_pin[gi]),
        .i_clr_n(i_rstn & ~st.async_clr[gi]),
        .i_sense(st.cfg[gi][`GPP_CFG_SENSE_LSB +: 3]),
        .i_inv(st.cfg[gi][`GPP_CFG_INV_BIT]),
        .o_hit(ahit[gi])
      );
      assign low_async[gi] = (st.cfg[gi][`GPP_CFG_SENSE_LSB +: 3] == `GPP_SENSE_LOW) &
                             (i_pin[gi] == st.cfg[gi][`GPP_CFG_INV_BIT]);
    end
  endgenerate

  assign sync_in = {ahit, i_rtc_clk, i_pin};

  gpp_sync #(
    .WIDTH(17)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign pin_s = sync_out[7:0];
  assign rtc_s = sync_out[8];
  assign ahit_s = sync_out[16:9];

  // clockless wake from latched edges or a held low level
  assign o_wake = |ahit | |low_async;

  logic acc;
  logic wr;
  logic [5:0] idx;
  logic [7:0] wb;
  logic [7:0] in_eff;
  logic [7:0] hit;
  logic [31:0] rdata;
  logic mapped;
  logic [2:0] sense;
  logic [2:0] opc;
  logic inv;
  logic o_eff;
  logic rise;
  logic fall;
  logic [2:0] clk_pin;
  logic [1:0] clr_flags;

  always_comb begin
    next_st = st;
    acc = i_psel & i_penable;
    wr = acc & st.pready & i_pwrite;
    idx = i_paddr[7:2];
    wb = i_pwdata[7:0];
    in_eff = '0;
    hit = '0;
    rdata = '0;
    mapped = 1'b1;
    sense = '0;
    opc = '0;
    inv = 1'b0;
    o_eff = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    clk_pin = st.clk_ctrl[`GPP_CLK_PIN_LSB +: 3];
    clr_flags = '0;

    // input path, sensing and events per pin
    for (int n = 0; n < `GPP_NPINS; n++) begin
      sense = st.cfg[n][`GPP_CFG_SENSE_LSB +: 3];
      inv = st.cfg[n][`GPP_CFG_INV_BIT];
      if (sense != `GPP_SENSE_INDIS) begin
        in_eff[n] = pin_s[n] ^ inv;
      end
      rise = in_eff[n] & ~st.in_prev[n];
      fall = ~in_eff[n] & st.in_prev[n];
      case (sense)
        `GPP_SENSE_BOTH: hit[n] = rise | fall;
        `GPP_SENSE_RISE: hit[n] = rise;
        `GPP_SENSE_FALL: hit[n] = fall;
        `GPP_SENSE_LOW: hit[n] = ~in_eff[n];
        default: hit[n] = 1'b0;
      endcase
      // events: clocked path only, edges pulse, level sensing follows high level
      if (sense == `GPP_SENSE_LOW) begin
        next_st.evt[n] = in_eff[n];
      end else begin
        next_st.evt[n] = hit[n] & (sense != `GPP_SENSE_INDIS);
      end
      // only pin 2 turns its latched edge straight into a request
      if (n == `GPP_FULL_ASYNC_PIN) begin
        hit[n] = hit[n] | ahit_s[n];
      end
      // clear the async catcher once seen, release once it reads idle
      next_st.async_clr[n] = ahit_s[n];
    end
    next_st.in_prev = in_eff;

    // apb read mux
    case (idx)
      `GPP_IDX_DIR, `GPP_IDX_DIRECTION_SET_PATH, `GPP_IDX_DIRCLR, `GPP_IDX_DIRTGL:
        rdata[7:0] = st.dir;
      `GPP_IDX_OUT, `GPP_IDX_OUTSET, `GPP_IDX_OUTCLR, `GPP_IDX_OUTTGL:
        rdata[7:0] = st.out;
      `GPP_IDX_IN: rdata[7:0] = in_eff;
      `GPP_IDX_INTCTRL: rdata[1:0] = st.int_en;
      `GPP_IDX_INT0MASK: rdata[7:0] = st.mask0;
      `GPP_IDX_INT1MASK: rdata[7:0] = st.mask1;
      `GPP_IDX_INTFLAGS: rdata[1:0] = st.iflag;
      `GPP_IDX_CLKOUT: rdata[7:0] = st.clk_ctrl;
      default: begin
        if (idx >= `GPP_IDX_PINCFG0 && idx <= `GPP_IDX_PINCFG7) begin
          rdata[7:0] = st.cfg[idx[2:0]];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase

    // one wait state: ready and data come from flops
    next_st.pready = acc & ~st.pready;
    if (acc & ~st.pready) begin
      next_st.prdata = i_pwrite ? 32'h0000_0000 : rdata;
      next_st.pslverr = ~mapped;
    end else begin
      next_st.pslverr = 1'b0;
    end

    // apb writes take effect on the completing edge
    if (wr && mapped) begin
      case (idx)
        `GPP_IDX_DIR: next_st.dir = wb;
        `GPP_IDX_DIRECTION_SET_PATH: next_st.dir = st.dir | wb;
        `GPP_IDX_DIRCLR: next_st.dir = st.dir & ~wb;
        `GPP_IDX_DIRTGL: next_st.dir = st.dir ^ wb;
        `GPP_IDX_OUT: next_st.out = wb;
        `GPP_IDX_OUTSET: next_st.out = st.out | wb;
        `GPP_IDX_OUTCLR: next_st.out = st.out & ~wb;
        `GPP_IDX_OUTTGL: next_st.out = st.out ^ wb;
        `GPP_IDX_INTCTRL: next_st.int_en = wb[1:0];
        `GPP_IDX_INT0MASK: next_st.mask0 = wb;
        `GPP_IDX_INT1MASK: next_st.mask1 = wb;
        `GPP_IDX_INTFLAGS: clr_flags = wb[1:0];
        `GPP_IDX_CLKOUT: next_st.clk_ctrl = wb;
        default: begin
          if (idx >= `GPP_IDX_PINCFG0 && idx <= `GPP_IDX_PINCFG7) begin
            next_st.cfg[idx[2:0]] = wb;
          end
        end
      endcase
    end

    // sticky flags, a new hit wins over a write-one clear
    next_st.iflag[0] = (st.iflag[0] & ~clr_flags[0]) | (|(hit & st.mask0));
    next_st.iflag[1] = (st.iflag[1] & ~clr_flags[1]) | (|(hit & st.mask1));
    next_st.irq = next_st.iflag & st.int_en;

    // pad drive from the registered settings
    for (int n = 0; n < `GPP_NPINS; n++) begin
      opc = st.cfg[n][`GPP_CFG_OPC_LSB +: 3];
      o_eff = st.out[n] ^ st.cfg[n][`GPP_CFG_INV_BIT];
      next_st.pad_o[n] = o_eff;
      next_st.pad_oe_n[n] = ~st.dir[n];
      next_st.pull_up[n] = 1'b0;
      next_st.pull_dn[n] = 1'b0;
      case (opc)
        `GPP_OPC_TOTEM: begin
          next_st.pad_o[n] = o_eff;
        end
        `GPP_OPC_KEEP: begin
          // keeper follows the last seen level, both directions
          next_st.pull_up[n] = pin_s[n];
          next_st.pull_dn[n] = ~pin_s[n];
        end
        `GPP_OPC_PDN: begin
          next_st.pull_dn[n] = ~st.dir[n];
        end
        `GPP_OPC_PUP: begin
          next_st.pull_up[n] = ~st.dir[n];
        end
        `GPP_OPC_WOR, `GPP_OPC_WORPD: begin
          next_st.pad_o[n] = 1'b1;
          next_st.pad_oe_n[n] = ~(st.dir[n] & o_eff);
          next_st.pull_dn[n] = (opc == `GPP_OPC_WORPD);
        end
        `GPP_OPC_WAND, `GPP_OPC_WANDPU: begin
          next_st.pad_o[n] = 1'b0;
          next_st.pad_oe_n[n] = ~(st.dir[n] & ~o_eff);
          next_st.pull_up[n] = (opc == `GPP_OPC_WANDPU);
        end
        default: begin
          next_st.pad_o[n] = o_eff;
        end
      endcase
    end

    // clock output on the selected pin overrides its driver
    next_st.clk_tgl = ~st.clk_tgl;
    if (st.clk_ctrl[`GPP_CLK_EN_BIT]) begin
      next_st.pad_oe_n[clk_pin] = 1'b0;
      next_st.pad_o[clk_pin] = st.clk_ctrl[`GPP_CLK_SRC_BIT] ? rtc_s : st.clk_tgl;
      next_st.pull_up[clk_pin] = 1'b0;
      next_st.pull_dn[clk_pin] = 1'b0;
    end
  end

  // async reset releases every pad at once
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_prdata = st.prdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_pin_out = st.pad_o;
  assign o_pin_oe_n = st.pad_oe_n;
  assign o_pull_up = st.pull_up;
  assign o_pull_dn = st.pull_dn;
  assign o_irq = st.irq;
  assign o_event = st.evt;

endmodule // gpp_port

// ==== hw/gpp_defs.svh ====
// constants for the general purpose I/O port: register indices, fields, reset values
// assumes a 32-bit APB slave; byte address of a register is its index times four
//
// Function
// - port has up to eight individually configured pins, numbered 0 to 7
// - direction bit one makes the pin an output, zero an input
// - output pin drives high for output bit one, low for zero
// - input bits show pin level in any direction, unless digital input disabled
// - all pins go high impedance at once on reset, even without clock
// - per-pin driver choice push-pull, wired-AND, wired-OR, plus input/output inversion
// - push-pull driver offers no pull, pull-down, pull-up or bus-keeper
// - push-pull pull resistors act only while the pin is an input
// - bus-keeper weakly holds last pin level, active in both directions
// - wired-OR drives high for output and direction one, else releases
// - wired-AND drives low for output zero, releases for output one
// - wired modes keep selected pull active as input and as output
// - pin level passes flip-flop then the input bit itself as synchronizer; here two gpp_sync flops feed the input bit, which is not a register
// - per-pin sensing of rising, falling, any edge or low level
// - sensed pin condition raises interrupt request or event
// - synchronous sensing needs the clock; asynchronous sensing needs none, wakes device
// - two interrupt outputs per port, each with its own pin mask
// - set, clear and toggle write paths change single pins safely
// - peripheral clock and real-time clock routable to a selectable pin
// - synchronous edge interrupt only after the clock sampled the changed value
// - only pin 2 latches edges asynchronously; others only any-edge and low level; here every pin latches, the others' latches only drive o_wake
// - low-level sensing keeps interrupt asserted while the pin stays low
// - writing one to direction-set sets that bit; reading returns direction
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

`define GPP_NPINS 8
`define GPP_FULL_ASYNC_PIN 2

// register indices
`define GPP_IDX_DIR 6'h00
`define GPP_IDX_DIRECTION_SET_PATH 6'h01
`define GPP_IDX_DIRCLR 6'h02
`define GPP_IDX_DIRTGL 6'h03
`define GPP_IDX_OUT 6'h04
`define GPP_IDX_OUTSET 6'h05
`define GPP_IDX_OUTCLR 6'h06
`define GPP_IDX_OUTTGL 6'h07
`define GPP_IDX_IN 6'h08
`define GPP_IDX_INTCTRL 6'h09
`define GPP_IDX_INT0MASK 6'h0A
`define GPP_IDX_INT1MASK 6'h0B
`define GPP_IDX_INTFLAGS 6'h0C
`define GPP_IDX_CLKOUT 6'h0D
`define GPP_IDX_PINCFG0 6'h10
`define GPP_IDX_PINCFG7 6'h17

// pin_config fields
`define GPP_CFG_SENSE_LSB 0
`define GPP_CFG_OPC_LSB 3
`define GPP_CFG_INV_BIT 6

// sense codes
`define GPP_SENSE_BOTH 3'h0
`define GPP_SENSE_RISE 3'h1
`define GPP_SENSE_FALL 3'h2
`define GPP_SENSE_LOW 3'h3
`define GPP_SENSE_INDIS 3'h7

// output/pull codes
`define GPP_OPC_TOTEM 3'h0
`define GPP_OPC_KEEP 3'h1
`define GPP_OPC_PDN 3'h2
`define GPP_OPC_PUP 3'h3
`define GPP_OPC_WOR 3'h4
`define GPP_OPC_WAND 3'h5
`define GPP_OPC_WORPD 3'h6
`define GPP_OPC_WANDPU 3'h7

// clock output control fields
`define GPP_CLK_EN_BIT 0
`define GPP_CLK_SRC_BIT 1
`define GPP_CLK_PIN_LSB 2

// reset values
`define GPP_DIR_RST 8'h00
`define GPP_OUT_RST 8'h00
`define GPP_OE_N_RST 8'hFF

`endif

// ==== hw/gpp_pkg.sv ====
// types shared by the general purpose I/O port design
// assumes gpp_defs.svh is on the include path
package gpp_pkg;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
    logic [7:0][7:0] cfg;
    logic [7:0] in_prev;
    logic [1:0] int_en;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [1:0] iflag;
    logic [7:0] clk_ctrl;
    logic clk_tgl;
    logic [7:0] async_clr;
    logic [7:0] pad_o;
    logic [7:0] pad_oe_n;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
    logic [1:0] irq;
    logic [7:0] evt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gpp_state_t;

endpackage

// ==== hw/gpp_sync.sv ====
// two-stage synchronizer for a vector of asynchronous levels
// assumes inputs may change at any time relative to i_sys_clk
`timescale 1ns/1ns
module gpp_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } gpp_sync_t;

  gpp_sync_t st;
  gpp_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.stage1 = i_async;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.stage2;

endmodule // gpp_sync

// ==== hw/gpp_edge_latch.sv ====
// clockless edge catcher for one pin, clocked by the pin itself
// assumes i_clr_n is glitch free (driven from a flop) and releases while pin is quiet
`timescale 1ns/1ns
`include "gpp_defs.svh"
module gpp_edge_latch #(
  parameter bit FULL = 1'b0
) (
  // pin and clear
  input wire logic i_pin,
  input wire logic i_clr_n,
  // pin setup
  input wire logic [2:0] i_sense,
  input wire logic i_inv,
  // result
  output logic o_hit
);

  logic rise_seen;
  logic fall_seen;
  logic eff_rise;
  logic eff_fall;

  always_ff @(posedge i_pin or negedge i_clr_n) begin
    if (!i_clr_n) begin
      rise_seen <= 1'b0;
    end else begin
      rise_seen <= 1'b1;
    end
  end

  always_ff @(negedge i_pin or negedge i_clr_n) begin
    if (!i_clr_n) begin
      fall_seen <= 1'b0;
    end else begin
      fall_seen <= 1'b1;
    end
  end

  // inversion swaps which pin edge is the sensed one
  always_comb begin
    eff_rise = i_inv ? fall_seen : rise_seen;
    eff_fall = i_inv ? rise_seen : fall_seen;
    o_hit = 1'b0;
    case (i_sense)
      `GPP_SENSE_BOTH: o_hit = eff_rise | eff_fall;
      `GPP_SENSE_RISE: o_hit = FULL & eff_rise;
      `GPP_SENSE_FALL: o_hit = FULL & eff_fall;
      `GPP_SENSE_LOW: o_hit = eff_fall;
      default: o_hit = 1'b0;
    endcase
  end

endmodule // gpp_edge_latch

// ==== tb/gpp_port_assertions.sv ====
// assertions on the apb answer and the reset state of the io port
// assumes it is bound to gpp_port and sees only its ports
`timescale 1ns/1ns
`include "gpp_defs.svh"
module gpp_port_assertions (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // pads and interrupts
  input wire logic [7:0] o_pin_oe_n,
  input wire logic [1:0] o_irq,
  input wire logic [7:0] o_event
);
  logic unmap;
  assign unmap = (i_paddr[7:2] > `GPP_IDX_CLKOUT && i_paddr[7:2] < `GPP_IDX_PINCFG0)
    || i_paddr[7:2] > `GPP_IDX_PINCFG7;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_wait;
    i_psel && i_penable && !$past(i_penable) |=> o_pready;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait state");
  property p_once;
    o_pready |=> !o_pready;
  endproperty
  a_once: assert property (p_once) else $error("ready held too long");
  property p_inacc;
    o_pready |-> i_psel && i_penable;
  endproperty
  a_inacc: assert property (p_inacc) else $error("ready outside access");
  property p_idle;
    !i_psel ##1 !i_psel |-> !o_pready;
  endproperty
  a_idle: assert property (p_idle) else $error("ready without request");
  property p_err;
    o_pslverr |-> o_pready && unmap;
  endproperty
  a_err: assert property (p_err) else $error("error on mapped index");
  property p_unmap;
    o_pready && unmap |-> o_pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped index accepted");
  property p_rdhi;
    o_pready |-> o_prdata[31:8] == 24'h0;
  endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
  property p_wrz;
    o_pready && i_pwrite |-> o_prdata == 32'h0;
  endproperty
  a_wrz: assert property (p_wrz) else $error("read data on write");
  property p_rst;
    $rose(i_rstn) |-> o_pin_oe_n == 8'hFF && o_irq == 2'h0 && o_event == 8'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("pads not released by reset");
  c_wr: cover property (o_pready && i_pwrite);
  c_rd: cover property (o_pready && !i_pwrite);
  c_err: cover property (o_pslverr);
endmodule // gpp_port_assertions

bind gpp_port gpp_port_assertions u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_pin_oe_n(o_pin_oe_n), .o_irq(o_irq), .o_event(o_event));

// ==== tb/gpp_pins_model.sv ====
// board around the port pins: port driver, external driver, pulls
// assumes registered pad requests; a floating wire flips every cycle
`timescale 1ns/1ns
module gpp_pins_model (
  // clock
  input wire logic i_sys_clk,
  // port pad requests
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe_n,
  input wire logic [7:0] i_pull_up,
  input wire logic [7:0] i_pull_dn,
  // external driver
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  // resolved wire
  output logic [7:0] o_level
);
  logic [7:0] last = 8'h00;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (!i_pin_oe_n[n]) o_level[n] = i_pin_out[n];
      else if (i_ext_en[n]) o_level[n] = i_ext_val[n];
      else if (i_pull_up[n]) o_level[n] = 1'b1;
      else if (i_pull_dn[n]) o_level[n] = 1'b0;
      else o_level[n] = ~last[n];
    end
  end
  always @(posedge i_sys_clk) last <= o_level;
endmodule // gpp_pins_model

// ==== tb/test_general_purpose_io_port.sv ====
// bench for the io port: write paths, pad drivers, pulls, sensing
// assumes the pin model closes the wire; expectations from bench ints
`timescale 1ns/1ns
`include "gpp_defs.svh"
module test_general_purpose_io_port;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rtc = 1'b0;
  logic [7:0] paddr = 8'h00, ext_val = 8'hFF, ext_en = 8'hFF;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] lvl, pout, poe_n, pup, pdn, evt, rd;
  logic [1:0] irq;
  logic pready, pslverr, wake, err;
  int bad_count, compares, seed = 32'h564d, dir, out, p, v, e, code, d, o, drv, lv, s, n, idle;
  gpp_port dut (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pin(lvl), .o_pin_out(pout),
    .o_pin_oe_n(poe_n), .o_pull_up(pup), .o_pull_dn(pdn), .i_rtc_clk(rtc),
    .o_irq(irq), .o_event(evt), .o_wake(wake));
  gpp_pins_model pins (.i_sys_clk(clk), .i_pin_out(pout), .i_pin_oe_n(poe_n),
    .i_pull_up(pup), .i_pull_dn(pdn), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(lvl));
  initial begin
    forever #5 clk = ~clk;
  end
  always begin
    repeat (4) @(posedge clk);
    rtc <= ~rtc;
  end
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    complete_run;
  end
  task automatic chk(input string nm, input int exp, input logic [7:0] got);
    compares++;
    if (got !== exp[7:0]) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", nm, exp[7:0], got);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] dat);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, dat};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      complete_run;
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [5:0] idx, input int exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
  endtask
  function automatic int upd(input int cur, input int path, input int val);
    case (path)
      0: return val;
      1: return cur | val;
      2: return cur & ~val;
      default: return cur ^ val;
    endcase
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    chk("reset oe_n", 8'hFF, poe_n);
    rstn <= 1'b1;
    @(posedge clk);
    rdc("reset dir", `GPP_IDX_DIR, 0);
    rdc("reset out", `GPP_IDX_OUT, 0);
    for (int k = 0; k < 32; k++) begin
      p = k % 8;
      v = $random(seed) & 255;
      e = $random(seed) & 255;
      apb(1'b1, 6'(p), 8'(v));
      if (p < 4) dir = upd(dir, p, v);
      else out = upd(out, p - 4, v);
      ext_en <= 8'(~dir);
      ext_val <= 8'(e);
      repeat (3) @(posedge clk);
      rdc("path read", 6'(p), p < 4 ? dir : out);
      chk("oe_n", ~dir, poe_n);
      chk("drive", dir & out, pout & 8'(dir));
      rdc("in", `GPP_IDX_IN, (dir & out) | (~dir & e));
    end
    for (int c = 0; c < 32; c++) begin
      code = c / 4;
      d = c / 2 % 2;
      o = c % 2;
      dir = d * 255;
      apb(1'b1, `GPP_IDX_PINCFG0 + 6'h3, 8'(code * 8));
      apb(1'b1, `GPP_IDX_DIR, 8'(dir));
      apb(1'b1, `GPP_IDX_OUT, 8'(o * 255));
      ext_en <= 8'(~dir);
      repeat (4) @(posedge clk);
      drv = code < 4 ? d : code % 2 ? d & (1 - o) : d & o;
      lv = d ? o : int'(ext_val[3]);
      chk("pad enable", 1 - drv, 8'(poe_n[3]));
      if (drv) chk("pad level", code < 4 ? o : 1 - code % 2, 8'(pout[3]));
      chk("pull up", (code == 3 && !d) || code == 7 || (code == 1 && lv), 8'(pup[3]));
      chk("pull down", (code == 2 && !d) || code == 6 || (code == 1 && !lv), 8'(pdn[3]));
    end
    apb(1'b1, `GPP_IDX_PINCFG0 + 6'h3, 8'h40);
    apb(1'b1, `GPP_IDX_PINCFG0 + 6'h4, 8'h07);
    apb(1'b1, `GPP_IDX_DIR, 8'h00);
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    repeat (3) @(posedge clk);
    rdc("in inverted", `GPP_IDX_IN, 8'hE7);
    apb(1'b1, `GPP_IDX_DIR, 8'hFF);
    apb(1'b1, `GPP_IDX_OUT, 8'h00);
    @(posedge clk);
    chk("inverted drive", 8'h08, pout & 8'h08);
    apb(1'b1, `GPP_IDX_DIR, 8'h00);
    apb(1'b1, `GPP_IDX_INTCTRL, 8'h03);
    apb(1'b1, `GPP_IDX_INT0MASK, 8'h01);
    apb(1'b1, `GPP_IDX_INT1MASK, 8'h02);
    for (int k = 0; k < 4; k++) begin
      s = k;
      idle = (s == 2 || s == 3);
      ext_val[0] <= idle[0];
      apb(1'b1, `GPP_IDX_PINCFG0, 8'(s));
      repeat (4) @(posedge clk);
      apb(1'b1, `GPP_IDX_INTFLAGS, 8'h03);
      @(posedge clk);
      chk("irq idle", 0, 8'(irq));
      ext_val[0] <= ~idle[0];
      for (n = 0; n < 10 && irq[0] !== 1'b1; n++) @(posedge clk);
      chk("irq raised", 1, 8'(irq[0]));
      chk("event on sense", s != 3, 8'(evt[0]));
      chk("irq masked", 0, 8'(irq[1]));
      apb(1'b1, `GPP_IDX_INTFLAGS, 8'h01);
      @(posedge clk);
      chk("irq after clear", s == 3, 8'(irq[0]));
      ext_val[0] <= idle[0];
      repeat (6) @(posedge clk);
      chk("event level", s == 3, 8'(evt[0]));
      if (s != 3) chk("irq on return", s == 0, 8'(irq[0]));
    end
    // clock out on pin 5: peripheral toggle, then synced rtc
    for (int m = 0; m < 2; m++) begin
      v = 1 << `GPP_CLK_EN_BIT | m << `GPP_CLK_SRC_BIT | 5 << `GPP_CLK_PIN_LSB;
      apb(1'b1, `GPP_IDX_CLKOUT, 8'(v));
      repeat (4) @(posedge clk);
      chk("clock pin enable", 0, 8'(poe_n[5]));
      n = 0;
      for (int t = 0; t < 8; t++) begin
        e = pout[5];
        @(posedge clk);
        n += (pout[5] !== e[0]);
      end
      chk("clock pin toggles", m ? 2 : 8, 8'(n));
    end
    apb(1'b1, `GPP_IDX_CLKOUT, 8'h00);
    repeat (8) @(posedge clk);
    chk("wake idle", 0, 8'(wake));
    ext_val[2] <= 1'b0;
    #1;
    chk("wake on edge", 1, 8'(wake));
    repeat (6) @(posedge clk);
    chk("wake cleared", 0, 8'(wake));
    apb(1'b0, 6'h0E, 8'h00);
    chk("slverr", 1, 8'(err));
    chk("unmapped data", 0, rd);
    apb(1'b1, `GPP_IDX_DIR, 8'hFF);
    rstn <= 1'b0;
    #2;
    chk("oe_n async reset", 8'hFF, poe_n);
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc("dir after reset", `GPP_IDX_DIR, 0);
    complete_run;
  end
endmodule // test_general_purpose_io_port
